/* lctc_pkg.sv */
// constants, types and tag decoding for the second-level cache tag controller
// assumes a direct-mapped cache with 32-byte lines and a 64-bit host bus
package lctc_pkg;
  localparam int STAT_DEPTH = 8192;
  localparam int SIDX_W = 13;
  localparam int TAG_W = 11;
  localparam int TIDX_W = 15;
  localparam int BEATS = 4;
  localparam int LEAD_CYC = 3;
  localparam int VALID_BIT = 6;
  localparam int DIRTY_BIT = 7;
  localparam int LIM64_LSB = 26;
  localparam int LIM512_LSB = 29;
  localparam int PCI_DEN = 5;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [1:0] ST_I = 2'h0;
  localparam logic [1:0] ST_E = 2'h1;
  localparam logic [1:0] ST_S = 2'h2;
  localparam logic [1:0] ST_M = 2'h3;
  localparam logic [1:0] STAT_RST = ST_I;

  typedef enum logic [1:0] {
    SZ_256K = 2'h0,
    SZ_512K = 2'h1,
    SZ_1M = 2'h2
  } lctc_size_e;

  typedef struct packed {
    lctc_size_e size;
    logic tag11;
    logic mcache;
    logic dyn_wb;
    logic single_alloc;
    logic linear_wrap;
  } lctc_cfg_s;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic burst;
    logic l1_wb;
  } lctc_req_s;

  // address bits held in the tag ram; valid bit left zero at 512KB and 1MB, dirty bit left zero at 1MB only
  function automatic logic [TAG_W-1:0] tag_word(logic [31:0] a,
                                                lctc_size_e s, logic t11);
    logic [TAG_W-1:0] t;
    t = '0;
    unique case (s)
      SZ_256K: t = t11 ? a[28:18] : {3'h0, a[25:18]};
      SZ_512K: begin
        t[5:0] = a[24:19];
        t[DIRTY_BIT] = a[25];
      end
      SZ_1M: t[5:0] = a[25:20];
      default: t = {3'h0, a[25:18]};
    endcase
    return t;
  endfunction

  function automatic logic [TAG_W-1:0] tag_mask(lctc_size_e s, logic t11);
    logic [TAG_W-1:0] m;
    m = tag_word('1, s, t11);
    return m;
  endfunction

  function automatic logic [TIDX_W-1:0] line_idx(logic [31:0] a,
                                                 lctc_size_e s);
    logic [TIDX_W-1:0] i;
    unique case (s)
      SZ_512K: i = {1'h0, a[18:5]};
      SZ_1M: i = a[19:5];
      default: i = {2'h0, a[17:5]};
    endcase
    return i;
  endfunction

  // victim line address rebuilt from stored tag and the line index
  function automatic logic [26:0] victim_line(logic [TAG_W-1:0] t,
                                              logic [31:0] a,
                                              lctc_size_e s, logic t11);
    logic [31:0] v;
    v = a;
    // index bits stay from the request, only the tag part is replaced
    unique case (s)
      SZ_512K: begin
        v[31:19] = '0;
        v[24:19] = t[5:0];
        v[25] = t[DIRTY_BIT];
      end
      SZ_1M: begin
        v[31:20] = '0;
        v[25:20] = t[5:0];
      end
      default: begin
        v[31:18] = '0;
        v[28:18] = t11 ? t : {3'h0, t[7:0]};
      end
    endcase
    return v[31:5];
  endfunction

  function automatic logic [1:0] beat_off(logic [1:0] base, logic [1:0] k,
                                          logic lin);
    return lin ? 2'(base + k) : (base ^ k);
  endfunction
endpackage

/* lctc_sync.sv */
// two-flop synchroniser for levels entering the host clock domain
// assumes inputs that may change at any time relative to mclk
`timescale 1ns/1ns
module lctc_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // first stage read by the second stage only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

/* lctc_ctrl.sv */
// direct-mapped second-level cache tag and state controller
// assumes synchronous tag ram with one cycle read latency and a memory
// controller that marks each 64-bit beat with mem_rdy
`timescale 1ns/1ns
// How it works
// RL1: direct-mapped L2 with MESI line state, write-back and dynamic write-back.
// RL2: line state of the 256KB cache lives in an on-chip 8Kx2 array.
// RL3: cache size 256KB, 512KB or 1MB chosen by configuration input.
// RL4: drives pipelined-burst SRAM with advance, or memory cache by address.
// RL5: with 8-bit tags only the low 64MB is cacheable.
// RL6: 11-bit tag option with 256KB makes 512MB cacheable.
// RL7: 1MB uses tag bit 6 valid, bit 7 dirty; 512KB uses bit 6 valid.
// RL8: dynamic write-back sends L1 writes straight to memory at 3-1-1-1.
// RL9: single-read allocation fills a whole line on a single read.
// RL10: linear-wrap burst order supported beside interleaved order.
// RL11: all these state machines run on the host clock; PCI logic elsewhere.
// RL12: PCI runs at host clock over 2.5, aligned every five host cycles.
// RL13: clock gate enable drops while host and PCI side are idle.
// RL14: slow 32K clock only times suspend refresh.
// RL15: a dirty victim is written back before the new line is filled.
// RL16: PCI-side requests are synchronised before the host logic uses them.
module lctc_ctrl (
  input wire logic mclk,
  input wire logic rstn,
  input wire lctc_pkg::lctc_cfg_s cfg,
  input wire logic req_valid,
  input wire lctc_pkg::lctc_req_s req,
  output logic req_ready,
  output logic host_rdy,
  output logic [31:3] host_beat_addr,
  output logic [lctc_pkg::TIDX_W-1:0] tag_addr,
  input wire logic [lctc_pkg::TAG_W-1:0] tag_rd,
  output logic [lctc_pkg::TAG_W-1:0] tag_wr,
  output logic tag_we,
  output logic [19:3] sram_addr,
  output logic sram_we,
  output logic sram_oe,
  output logic sram_adv,
  output logic mem_req,
  output logic mem_write,
  output logic [31:3] mem_addr,
  input wire logic mem_rdy,
  input wire logic pci_hold_req,
  output logic pci_hold_ack,
  input wire logic suspend_active,
  input wire logic suspend_refresh_clock,
  output logic refresh_req,
  output logic clk_gate_en,
  output logic pci_xfer_en
);
  import lctc_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_LOOK = 7'h02,
    S_WBACK = 7'h04,
    S_FILL = 7'h08,
    S_HIT = 7'h10,
    S_MEM = 7'h20,
    S_UPD = 7'h40
  } lctc_st_e;

  lctc_st_e st_r, st_nxt;
  lctc_req_s rq_r;
  logic [1:0] stat_r [STAT_DEPTH];
  logic [1:0] beat_r, boff_r, stat_wd;
  logic [TAG_W-1:0] tag_r, tword;
  logic [26:0] vline_r;
  logic [SIDX_W-1:0] sidx;
  logic [1:0] sy;
  logic [2:0] ph_r;
  logic rclk_d_r, take, adv, last, stat_we, sbit;
  logic cach, valid_l, dirty_l, hit, vdirty, dwb, dwb_hit;

  assign take = req_valid && req_ready;
  assign sidx = rq_r.addr[17:5];
  assign sbit = rq_r.addr[18];
  assign tword = tag_word(rq_r.addr, cfg.size, cfg.tag11);

  lctc_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din({suspend_refresh_clock, pci_hold_req}),
    .dout(sy)
  );

  // PCI owns memory while held; host requests wait in idle [RL16]
  assign pci_hold_ack = (st_r == S_IDLE) && sy[0];
  assign req_ready = (st_r == S_IDLE) && !sy[0];
  // tag read starts in the taking cycle to keep the 3-1-1-1 lead
  assign tag_addr = line_idx((st_r == S_IDLE) ? req.addr : rq_r.addr,
                             cfg.size); // [RL3]

  // cacheable limit: 512MB only with 11-bit tags on 256KB [RL5] [RL6]
  assign cach = (cfg.size == SZ_256K && cfg.tag11) ?
                (rq_r.addr[31:LIM512_LSB] == '0) :
                (rq_r.addr[31:LIM64_LSB] == '0);
  // valid and dirty from the status array or tag bits [RL2] [RL7]
  always_comb begin
    unique case (cfg.size)
      SZ_512K: begin
        valid_l = tag_rd[VALID_BIT];
        dirty_l = stat_r[sidx][sbit];
      end
      SZ_1M: begin
        valid_l = tag_rd[VALID_BIT];
        dirty_l = tag_rd[DIRTY_BIT];
      end
      default: begin
        valid_l = stat_r[sidx] != ST_I;
        dirty_l = stat_r[sidx] == ST_M;
      end
    endcase
  end
  assign hit = cach && valid_l &&
               ((tag_rd & tag_mask(cfg.size, cfg.tag11)) == tword);
  assign vdirty = cach && valid_l && dirty_l;
  assign dwb = rq_r.write && rq_r.l1_wb && cfg.dyn_wb;
  assign dwb_hit = (st_r == S_LOOK) && dwb && hit;

  always_comb begin
    unique case (st_r)
      S_HIT: adv = 1'b1;
      S_WBACK, S_FILL, S_MEM: adv = mem_rdy;
      default: adv = 1'b0;
    endcase
  end
  assign last = (beat_r == LAST_BEAT) ||
                (!rq_r.burst && (st_r == S_HIT || st_r == S_MEM));

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (take) st_nxt = S_LOOK;
      S_LOOK: begin
        if (!cach || dwb) begin
          st_nxt = S_MEM; // [RL5] [RL8]
        end else if (hit) begin
          st_nxt = S_HIT;
        end else if (rq_r.write) begin
          st_nxt = S_MEM;
        end else if (rq_r.burst || cfg.single_alloc) begin
          st_nxt = vdirty ? S_WBACK : S_FILL; // [RL9] [RL15]
        end else begin
          st_nxt = S_MEM;
        end
      end
      S_WBACK: if (adv && last) st_nxt = S_FILL; // [RL15]
      S_FILL: if (adv && last) st_nxt = S_UPD;
      S_HIT, S_MEM: if (adv && last) st_nxt = S_IDLE;
      S_UPD: st_nxt = S_IDLE;
    endcase
  end

  // host clock drives every state machine here [RL11]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) st_r <= S_IDLE;
    else st_r <= st_nxt;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rq_r <= '0;
      tag_r <= '0;
      vline_r <= '0;
    end else if (take) begin
      rq_r <= req;
    end else if (st_r == S_LOOK) begin
      tag_r <= tag_rd;
      vline_r <= victim_line(tag_rd, rq_r.addr, cfg.size, cfg.tag11);
    end
  end

  // beat order: interleaved or linear wrap from the critical word [RL10]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      beat_r <= '0;
      boff_r <= '0;
    end else if (take) begin
      beat_r <= '0;
      boff_r <= req.addr[4:3];
    end else if (adv) begin
      beat_r <= last ? 2'h0 : 2'(beat_r + 2'h1);
      boff_r <= beat_off(rq_r.addr[4:3], last ? 2'h0 : 2'(beat_r + 2'h1),
                         cfg.linear_wrap); // [RL10]
    end
  end

  // hit read or write runs 3-1-1-1 from the taking cycle [RL1]
  assign host_rdy = (st_r == S_HIT) ||
                    (st_r == S_MEM && mem_rdy) ||
                    (st_r == S_FILL && mem_rdy &&
                     (rq_r.burst || beat_r == 2'h0)); // [RL9]
  assign host_beat_addr = {rq_r.addr[31:5], boff_r};

  // victim leaves in plain order, fills arrive critical word first
  assign mem_req = (st_r == S_WBACK) || (st_r == S_FILL) || (st_r == S_MEM);
  assign mem_write = (st_r == S_WBACK) || (st_r == S_MEM && rq_r.write);
  assign mem_addr = (st_r == S_WBACK) ? {vline_r, beat_r} :
                    {rq_r.addr[31:5], boff_r}; // [RL15] [RL8]

  assign sram_addr = {rq_r.addr[19:5],
                      (st_r == S_WBACK) ? beat_r : boff_r};
  assign sram_we = (st_r == S_HIT && rq_r.write) ||
                   (st_r == S_FILL && mem_rdy);
  assign sram_oe = (st_r == S_HIT && !rq_r.write) || (st_r == S_WBACK);
  // memory cache takes a full address each beat, no advance [RL4]
  assign sram_adv = !cfg.mcache && beat_r != 2'h0 &&
                    (st_r == S_HIT || st_r == S_WBACK || st_r == S_FILL);

  // tag ram writes: new tag on every fill, plus valid or dirty changes for sizes that keep them in the tag [RL7]
  always_comb begin
    tag_we = 1'b0;
    tag_wr = tword;
    if (dwb_hit && cfg.size != SZ_256K) begin
      tag_we = 1'b1;
      tag_wr = tag_rd & ~(TAG_W'(1) << VALID_BIT);
    end else if (st_r == S_HIT && rq_r.write && beat_r == 2'h0 &&
                 cfg.size == SZ_1M) begin
      tag_we = 1'b1;
      tag_wr = tag_r | (TAG_W'(1) << DIRTY_BIT);
    end else if (st_r == S_UPD) begin
      tag_we = 1'b1;
      if (cfg.size != SZ_256K) tag_wr = tword | (TAG_W'(1) << VALID_BIT);
    end
  end

  // status array: MESI for 256KB, one dirty bit per line for 512KB [RL2]
  always_comb begin
    stat_wd = stat_r[sidx];
    stat_we = 1'b0;
    if (cfg.size != SZ_1M) begin
      if (dwb_hit || st_r == S_UPD || (st_r == S_HIT && rq_r.write)) begin
        stat_we = 1'b1;
      end
      if (cfg.size == SZ_512K) begin
        stat_wd[sbit] = (st_r == S_HIT); // [RL7]
      end else if (st_r == S_HIT) begin
        stat_wd = ST_M; // [RL1]
      end else begin
        stat_wd = dwb_hit ? ST_I : ST_E;
      end
    end
  end

  // large flop array reset costs area but keeps every 256KB line invalid
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < STAT_DEPTH; i++) stat_r[i] <= STAT_RST;
    end else if (stat_we) begin
      stat_r[sidx] <= stat_wd; // [RL2]
    end
  end

  // host and PCI edges meet once every five host cycles [RL12]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ph_r <= '0;
    else if (ph_r == 3'(PCI_DEN - 1)) ph_r <= '0;
    else ph_r <= 3'(ph_r + 3'h1);
  end
  assign pci_xfer_en = ph_r == '0;

  // clocks may stop only when nothing is pending on either side [RL13]
  assign clk_gate_en = (st_r != S_IDLE) || req_valid || sy[0];

  // slow clock edge only counts while suspended [RL14]
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rclk_d_r <= 1'b0;
      refresh_req <= 1'b0;
    end else begin
      rclk_d_r <= sy[1];
      refresh_req <= suspend_active && sy[1] && !rclk_d_r;
    end
  end

  hit_lead_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL1]
    take ##1 (st_nxt == S_HIT) |=> host_rdy)
    else $error("hit data not on third clock");
  hit_burst_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL1]
    (st_r == S_LOOK && st_nxt == S_HIT && rq_r.burst) |=>
      host_rdy [*4] ##1 !host_rdy)
    else $error("hit burst not four beats");
  dirty_wb_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL15]
    (st_r == S_LOOK && vdirty && !hit && !rq_r.write && rq_r.burst) |=>
      st_r == S_WBACK && mem_write)
    else $error("dirty victim not written back");
  noncache_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL5]
    (st_r == S_LOOK && !cach) |=> st_r == S_MEM && !sram_we)
    else $error("uncacheable access touched cache");
  single_fill_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL9]
    (st_r == S_LOOK && cach && !hit && !rq_r.write && cfg.single_alloc)
      |=> st_r inside {S_WBACK, S_FILL})
    else $error("single read not allocated");
  mark_dirty_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL2]
    (st_r == S_HIT && rq_r.write && cfg.size == SZ_256K) |=>
      stat_r[sidx] == ST_M)
    else $error("write hit line not modified");
  array_off_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL7]
    cfg.size == SZ_1M |-> !stat_we)
    else $error("status array used at 1MB");
  dwb_route_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL8]
    (st_r == S_LOOK && dwb) |=> mem_req && mem_write && !sram_we)
    else $error("dynamic write-back not sent to memory");
  phase_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL12]
    pci_xfer_en |=> !pci_xfer_en [*4] ##1 pci_xfer_en)
    else $error("pci alignment not every five clocks");
  refresh_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL14]
    refresh_req |-> $past(suspend_active) && !$past(refresh_req))
    else $error("refresh outside suspend");
  hold_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL16]
    pci_hold_ack |-> !req_ready && clk_gate_en)
    else $error("host taken during pci hold");
endmodule

/* lctc_far_model.sv */
// far side: external tag ram and a main memory that may stall
// assumes the bench drives go and wipe just after mclk rising edges
`timescale 1ns/1ns
module lctc_far_model (
  input wire logic mclk,
  input wire logic wipe,
  input wire logic go,
  input wire logic [lctc_pkg::TIDX_W-1:0] tag_addr,
  input wire logic [lctc_pkg::TAG_W-1:0] tag_wr,
  input wire logic tag_we,
  output logic [lctc_pkg::TAG_W-1:0] tag_rd,
  input wire logic mem_req,
  output logic mem_rdy
);
  import lctc_pkg::*;
  logic [TAG_W-1:0] tram [2**TIDX_W];
  initial tag_rd = '0;
  // wipe stands in for software flushing tags between configurations
  always @(posedge mclk) begin
    if (wipe) begin
      for (int i = 0; i < 2**TIDX_W; i++) tram[i] <= '0;
    end else if (tag_we) begin
      tram[tag_addr] <= tag_wr;
    end
  end
  // synchronous ram: old word seen on a same-edge write
  always @(posedge mclk) tag_rd <= tram[tag_addr];
  // no beat moves unless asked, stall pattern from the bench
  assign mem_rdy = mem_req & go;
endmodule

/* lctc_ctrl_tb_top.sv */
// self-checking bench for the cache tag controller
// assumes lctc_far_model for tag ram and memory; config held per pass
`timescale 1ns/1ns
module lctc_ctrl_tb_top;
  import lctc_pkg::*;
  logic mclk, rstn, req_valid, pci_hold_req, suspend_active;
  logic suspend_refresh_clock, wipe, go, slow;
  lctc_cfg_s cfg;
  lctc_req_s req;
  logic req_ready, host_rdy, tag_we, sram_we, sram_oe, sram_adv;
  logic mem_req, mem_write, mem_rdy, pci_hold_ack, refresh_req;
  logic clk_gate_en, pci_xfer_en;
  logic [31:3] host_beat_addr, mem_addr;
  logic [19:3] sram_addr;
  logic [TIDX_W-1:0] tag_addr;
  logic [TAG_W-1:0] tag_rd, tag_wr;
  int err_count, checks_done, ncyc, first, last, hb, rdb, wrb, wrpre;
  int dirt, advs, refr, n, swe;
  logic [31:0] seed, gs;
  logic [31:3] aq[$];
  logic [31:3] vic;

  lctc_ctrl i_lctc_ctrl (
    .mclk, .rstn, .cfg, .req_valid, .req, .req_ready, .host_rdy,
    .host_beat_addr, .tag_addr, .tag_rd, .tag_wr, .tag_we, .sram_addr,
    .sram_we, .sram_oe, .sram_adv, .mem_req, .mem_write, .mem_addr,
    .mem_rdy, .pci_hold_req, .pci_hold_ack, .suspend_active,
    .suspend_refresh_clock, .refresh_req, .clk_gate_en, .pci_xfer_en
  );
  lctc_far_model i_lctc_far_model (
    .mclk, .wipe, .go, .tag_addr, .tag_wr, .tag_we, .tag_rd, .mem_req,
    .mem_rdy
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected beat address: linear counts up, interleaved flips bits
  function automatic logic [31:3] beat_exp(input logic [31:0] a,
                                           input int k, input logic lin);
    logic [1:0] off;
    off = lin ? 2'(a[4:3] + k[1:0]) : (a[4:3] ^ k[1:0]);
    return {a[31:5], off};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // stall pattern on its own stream so main-thread draws stay repeatable
  always @(posedge mclk) begin
    gs <= xs(gs);
    go <= !slow | gs[0];
  end

  // outputs sampled mid-cycle, where they have settled
  always @(negedge mclk) begin
    ncyc++;
    if (host_rdy === 1'b1) begin
      if (first == 0) first = ncyc;
      last = ncyc;
      hb++;
      aq.push_back(host_beat_addr);
    end
    if (mem_req && mem_rdy && mem_write) begin
      if (wrb == 0) vic = mem_addr;
      wrb++;
    end
    if (mem_req && mem_rdy && !mem_write) begin
      if (rdb == 0) wrpre = wrb;
      rdb++;
    end
    dirt += int'(tag_we === 1'b1 && tag_wr[DIRTY_BIT] === 1'b1);
    advs += int'(sram_adv === 1'b1);
    swe += int'(sram_we === 1'b1);
    refr += int'(refresh_req === 1'b1);
  end

  task automatic do_reset(input lctc_cfg_s c);
    @(posedge mclk);
    rstn <= 1'b0;
    cfg <= c;
    wipe <= 1'b1;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    wipe <= 1'b0;
  endtask

  // one request, held until taken, then wait for return to idle
  task automatic xfer(input logic [31:0] a, input logic w, b, l);
    int k;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{addr: a, write: w, burst: b, l1_wb: l};
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (req_ready !== 1'b1 && k < 200);
    @(posedge mclk);
    req_valid <= 1'b0;
    {ncyc, first, hb, rdb, wrb, wrpre, dirt, advs, swe} = '0;
    vic = '0;
    aq.delete();
    do begin
      @(negedge mclk);
      k++;
    end while (req_ready !== 1'b1 && k < 600);
    chk(k < 600, 1, "hang");
    @(posedge mclk);
  endtask

  task automatic chk_order(input logic [31:0] a);
    for (int k = 0; k < 4; k++) begin
      chk(aq[k], beat_exp(a, k, cfg.linear_wrap), "beat addr");
    end
  endtask

  task automatic pass(input lctc_cfg_s c, input logic [31:0] hi);
    logic [31:0] a, bb;
    do_reset(c);
    seed = xs(seed);
    a = (seed & 32'h01ff_fff8) | hi;
    bb = a ^ (32'h4_0000 << c.size);
    xfer(a, 1'b0, 1'b1, 1'b0);
    chk(hb, 4, "miss beats");
    chk(rdb, 4, "fill beats");
    chk_order(a);
    xfer(a, 1'b0, 1'b1, 1'b0);
    chk(rdb, 0, "hit mem");
    chk(first, 2, "hit lead");
    chk(last, 5, "hit last");
    chk(advs, c.mcache ? 0 : 3, "advance");
    chk_order(a);
    xfer(a, 1'b1, 1'b1, 1'b0);
    chk(wrb, 0, "write hit mem");
    chk(swe, BEATS, "write hit sram");
    chk(dirt > 0, c.size == SZ_1M, "dirty tag");
    xfer(bb, 1'b0, 1'b1, 1'b0);
    chk(wrb, 4, "victim out");
    chk(wrpre, 4, "victim first");
    chk(vic, {a[31:5], 2'h0}, "victim addr");
    chk(rdb, 4, "refill");
  endtask

  task automatic tick32k();
    repeat (20) @(posedge mclk);
    suspend_refresh_clock <= 1'b1;
    repeat (20) @(posedge mclk);
    suspend_refresh_clock <= 1'b0;
  endtask

  initial begin
    {rstn, req_valid, pci_hold_req, suspend_active, slow} = '0;
    suspend_refresh_clock = 1'b0;
    {wipe, go} = 2'h3;
    req = '0;
    cfg = '0;
    seed = 32'h3703ceca;
    gs = 32'h3703ceca;
    pass('{SZ_256K, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, 32'h0);
    repeat (2) xfer(32'h0400_0120, 1'b0, 1'b1, 1'b0);
    chk(rdb, 4, "uncached");
    slow = 1'b1;
    pass('{SZ_512K, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}, 32'h0);
    xfer(32'h0012_3458, 1'b0, 1'b0, 1'b0);
    chk(hb, 1, "single host");
    chk(rdb, 4, "single fill");
    xfer(32'h0012_3440, 1'b0, 1'b1, 1'b0);
    chk(rdb, 0, "after alloc");
    pass('{SZ_1M, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}, 32'h0);
    xfer(32'h0023_4560, 1'b0, 1'b1, 1'b0);
    xfer(32'h0023_4560, 1'b1, 1'b1, 1'b1);
    chk(wrb, 4, "dyn wb beats");
    chk(hb, 4, "dyn wb host");
    xfer(32'h0023_4560, 1'b0, 1'b1, 1'b0);
    chk(rdb, 4, "dyn wb dropped line");
    pass('{SZ_256K, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}, 32'h1000_0000);
    n = 0;
    repeat (20) begin
      @(negedge mclk);
      n += int'(pci_xfer_en === 1'b1);
    end
    chk(n, 4, "pci slots");
    chk(clk_gate_en, 0, "gate idle");
    @(posedge mclk);
    pci_hold_req <= 1'b1;
    repeat (4) @(negedge mclk);
    chk(pci_hold_ack, 1, "hold ack");
    chk(req_ready, 0, "hold refuse");
    chk(clk_gate_en, 1, "gate busy");
    @(posedge mclk);
    pci_hold_req <= 1'b0;
    repeat (4) @(negedge mclk);
    chk(pci_hold_ack, 0, "hold end");
    @(posedge mclk);
    refr = 0;
    suspend_active <= 1'b1;
    repeat (3) tick32k();
    repeat (8) @(posedge mclk);
    chk(refr, 3, "refresh");
    suspend_active <= 1'b0;
    tick32k();
    repeat (8) @(posedge mclk);
    chk(refr, 3, "no refresh");
    complete_run();
  end

  // well beyond the few hundred cycles the sequence needs
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule
